// file: include/bwb_regs.vh
`ifndef BWB_REGS_VH
`define BWB_REGS_VH

// ****************************************
// Short-address configuration registers
// ****************************************
`define BWB_OFS_CARD_PFS     6'h14
`define BWB_OFS_IMAGE_PFS    6'h16
`define BWB_OFS_CARD_WTH     6'h18
`define BWB_OFS_IMAGE_WTH    6'h1a
`define BWB_OFS_SWAP         6'h1e
`define BWB_OFS_OPTION       6'h32
`define BWB_OFS_CONTROL      6'h06
`define BWB_OFS_OFFSET       6'h08
`define BWB_CTRL_ENABLE_BIT  15
`define BWB_IMAGE_MASK       16'h003f
`define BWB_SWAP_MASK        16'h7fff
`define BWB_OFFSET_MASK      16'hf000

// ****************************************
// Cycle kinds and widths
// ****************************************
`define BWB_CYC_SCT          2'h0
`define BWB_CYC_BLT          2'h1
`define BWB_CYC_MBLT         2'h2
`define BWB_CYC_2E           2'h3
`define BWB_W16              1'b0
`define BWB_W32              1'b1

// ****************************************
// Wide window offsets (28 bits)
// ****************************************
`define BWB_WIN_SINGLE       28'h2000000
`define BWB_WIN_SINGLE_END   28'h20fffff
`define BWB_WIN_PAIR         28'h2200000
`define BWB_WIN_QUAD         28'h2400000
`define BWB_WIN_BCAST        28'h2600000
`define BWB_WIN_BCAST_END    28'h261ffff
`define BWB_WIN_COMMON_END   28'h1ffffff
`define BWB_WIN_BLOCK_SHIFT  21

// ****************************************
// Target classes
// ****************************************
`define BWB_TGT_NONE         3'h0
`define BWB_TGT_COMMON       3'h1
`define BWB_TGT_CARD         3'h2
`define BWB_TGT_IMAGE        3'h3

// ****************************************
// Beat counts per 2-bit code
// ****************************************
`define BWB_BEATS_00         7'h01
`define BWB_BEATS_01         7'h08
`define BWB_BEATS_10         7'h10
`define BWB_BEATS_11         7'h40

`endif

// file: verilog/bwb_fifo.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Write data buffer
// ****************************************
module bwb_fifo #(
  parameter WIDTH = 64,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             i_mclk,
  input  wire             i_sys_rst,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_valid,
  output wire             o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire             o_valid,
  input  wire             i_ready,
  output wire [AW:0]      o_level
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW:0]      wr_reg;
  reg [AW:0]      rd_reg;
  wire            push;
  wire            pop;

  assign o_level = wr_reg - rd_reg;
  assign o_ready = (o_level != DEPTH[AW:0]);
  assign o_valid = (wr_reg != rd_reg);
  assign o_data  = mem_reg[rd_reg[AW-1:0]];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always @(posedge i_mclk) begin
    if (push) begin
      mem_reg[wr_reg[AW-1:0]] <= i_data;
    end
  end

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_reg <= {(AW+1){1'b0}};
      rd_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// file: verilog/bwb_bridge.v
// Functional notes
// - Prefetch code gives 1, 8, 16, 64 beats
// - Eight card prefetch fields, card 8 top
// - Beat width follows current cycle width
// - Parallel read uses smallest card prefetch
// - Three image prefetch fields, upper reserved
// - Threshold code gives 1, 8, 16, 64 beats
// - Parallel write uses smallest card threshold
// - Three image threshold fields, upper reserved
// - Swap halves for 32, halfword pairs for 64
// - Swap applies to reads and writes alike
// - Bits 14:11 swap the quad windows
// - Eight bits swap the paired windows
// - Two bits swap images three and two
// - Option code read-only in bits 7:0
// - 256 MB window active once enabled
// - Accept single, block, multiplexed, double-edge cycles
// - Common registers, then eight single-card windows
// - Eight paired windows, no 16-bit cycles
// - Four quad windows, 64-bit cycles only
// - Broadcast window at 0x2600000, writes only
// - Three 64 MB memory image windows
// - Offset bits 15:12 match address 31:28
`timescale 1ns/1ps
`default_nettype none
`include "bwb_regs.vh"

module bwb_bridge #(
  parameter [7:0] OPTION_CODE = 8'h5a, // Arbitrary value, strapped per board build
  parameter       FIFO_DEPTH  = 8
) (
  input  wire        i_mclk,
  input  wire        i_sys_rst,
  input  wire        i_cfg_wr,
  input  wire        i_cfg_rd,
  input  wire [5:0]  i_cfg_addr,
  input  wire [15:0] i_cfg_wdata,
  output reg  [15:0] o_cfg_rdata,
  input  wire        i_cyc_valid,
  output wire        o_cyc_ready,
  input  wire [31:0] i_cyc_addr,
  input  wire [1:0]  i_cyc_kind,
  input  wire        i_cyc_width,
  input  wire        i_cyc_write,
  input  wire [63:0] i_cyc_wdata,
  output reg         o_cyc_done,
  output reg         o_cyc_err,
  output reg  [63:0] o_cyc_rdata,
  output reg  [2:0]  o_tgt_class,
  output reg  [7:0]  o_tgt_cards,
  output reg  [1:0]  o_tgt_image,
  output reg  [22:0] o_tgt_offset,
  output reg         o_tgt_write,
  output reg  [6:0]  o_tgt_prefetch_beats,
  output reg  [6:0]  o_tgt_threshold_beats,
  output reg  [3:0]  o_tgt_beat_bytes,
  output reg         o_tgt_req,
  input  wire        i_tgt_ack,
  input  wire [63:0] i_tgt_rdata,
  output wire [63:0] o_wbuf_data,
  output wire        o_wbuf_valid,
  input  wire        i_wbuf_ready,
  output wire        o_window_enable
);

  // ****************************************
  // Configuration registers
  // ****************************************
  reg [15:0] card_prefetch_depth_reg;
  reg [15:0] image_prefetch_depth_reg;
  reg [15:0] card_write_threshold_reg;
  reg [15:0] image_write_threshold_reg;
  reg [15:0] halfword_swap_control_reg;
  reg [15:0] offset_reg;
  reg        wide_window_enable_reg;

  assign o_window_enable = wide_window_enable_reg;

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      card_prefetch_depth_reg   <= 16'h0000;
      image_prefetch_depth_reg  <= 16'h0000;
      card_write_threshold_reg  <= 16'h0000;
      image_write_threshold_reg <= 16'h0000;
      halfword_swap_control_reg <= 16'h0000;
      offset_reg                <= 16'h0000;
      wide_window_enable_reg    <= 1'b0;
    end else if (i_cfg_wr) begin
      case (i_cfg_addr)
        `BWB_OFS_CARD_PFS: begin
          card_prefetch_depth_reg <= i_cfg_wdata;
        end
        `BWB_OFS_IMAGE_PFS: begin
          image_prefetch_depth_reg <= i_cfg_wdata & `BWB_IMAGE_MASK;
        end
        `BWB_OFS_CARD_WTH: begin
          card_write_threshold_reg <= i_cfg_wdata;
        end
        `BWB_OFS_IMAGE_WTH: begin
          image_write_threshold_reg <= i_cfg_wdata & `BWB_IMAGE_MASK;
        end
        `BWB_OFS_SWAP: begin
          halfword_swap_control_reg <= i_cfg_wdata & `BWB_SWAP_MASK;
        end
        `BWB_OFS_OFFSET: begin
          offset_reg <= i_cfg_wdata & `BWB_OFFSET_MASK;
        end
        `BWB_OFS_CONTROL: begin
          wide_window_enable_reg <= i_cfg_wdata[`BWB_CTRL_ENABLE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Control is write-only, so it reads back as zero like any unmapped offset
  always @* begin
    case (i_cfg_addr)
      `BWB_OFS_CARD_PFS:   o_cfg_rdata = card_prefetch_depth_reg;
      `BWB_OFS_IMAGE_PFS:  o_cfg_rdata = image_prefetch_depth_reg;
      `BWB_OFS_CARD_WTH:   o_cfg_rdata = card_write_threshold_reg;
      `BWB_OFS_IMAGE_WTH:  o_cfg_rdata = image_write_threshold_reg;
      `BWB_OFS_SWAP:       o_cfg_rdata = halfword_swap_control_reg;
      `BWB_OFS_OPTION:     o_cfg_rdata = {8'h00, OPTION_CODE};
      `BWB_OFS_OFFSET:     o_cfg_rdata = offset_reg;
      default:             o_cfg_rdata = 16'h0000;
    endcase
  end

  // ****************************************
  // Helper functions
  // ****************************************
  function [6:0] beats_of;
    input [1:0] code;
    begin
      case (code)
        2'h0:    beats_of = `BWB_BEATS_00;
        2'h1:    beats_of = `BWB_BEATS_01;
        2'h2:    beats_of = `BWB_BEATS_10;
        default: beats_of = `BWB_BEATS_11;
      endcase
    end
  endfunction

  // Smallest code among selected cards; codes are monotonic in beats
  function [1:0] min_code;
    input [15:0] fields;
    input [7:0]  sel;
    integer      k;
    reg   [1:0]  m;
    begin
      m = 2'h3;
      for (k = 0; k < 8; k = k + 1) begin
        if (sel[k] && (fields[2*k +: 2] < m)) begin
          m = fields[2*k +: 2];
        end
      end
      min_code = m;
    end
  endfunction

  function [63:0] swap_halves;
    input [63:0] d;
    input        wide;
    begin
      if (wide) begin
        swap_halves = {d[47:32], d[63:48], d[15:0], d[31:16]};
      end else begin
        swap_halves = {d[63:32], d[15:0], d[31:16]};
      end
    end
  endfunction

  // ****************************************
  // Address decode
  // ****************************************
  wire [27:0] offs   = i_cyc_addr[27:0];
  wire        is64   = (i_cyc_kind == `BWB_CYC_MBLT) || (i_cyc_kind == `BWB_CYC_2E);
  wire        is16   = !is64 && (i_cyc_width == `BWB_W16);
  wire        hit    = wide_window_enable_reg && (i_cyc_addr[31:28] == offset_reg[15:12]);
  wire [2:0]  pidx   = offs[20:18];
  wire [1:0]  qidx   = offs[20:19];

  reg  [2:0]  dec_class;
  reg  [7:0]  dec_cards;
  reg  [1:0]  dec_image;
  reg         dec_swap;
  reg         dec_bad;

  always @* begin
    dec_class = `BWB_TGT_NONE;
    dec_cards = 8'h00;
    dec_image = 2'h0;
    dec_swap  = 1'b0;
    dec_bad   = 1'b0;
    if (offs <= `BWB_WIN_COMMON_END) begin
      dec_class = `BWB_TGT_COMMON;
    end else if (offs <= `BWB_WIN_SINGLE_END && offs >= `BWB_WIN_SINGLE) begin
      dec_class = `BWB_TGT_CARD;
      dec_cards = 8'h01 << offs[19:17];
    end else if ((offs >> `BWB_WIN_BLOCK_SHIFT) == (`BWB_WIN_PAIR >> `BWB_WIN_BLOCK_SHIFT)) begin
      dec_class = `BWB_TGT_CARD;
      dec_bad   = is16;
      case (pidx)
        3'h0:    dec_cards = 8'h05;
        3'h1:    dec_cards = 8'h0a;
        3'h2:    dec_cards = 8'h50;
        3'h3:    dec_cards = 8'ha0;
        3'h4:    dec_cards = 8'h03;
        3'h5:    dec_cards = 8'h0c;
        3'h6:    dec_cards = 8'h30;
        default: dec_cards = 8'hc0;
      endcase
      // Four-bit index arithmetic, a three-bit difference would wrap for the first two windows
      dec_swap = halfword_swap_control_reg[4'h9 - {1'b0, pidx}];
    end else if ((offs >> `BWB_WIN_BLOCK_SHIFT) == (`BWB_WIN_QUAD >> `BWB_WIN_BLOCK_SHIFT)) begin
      dec_class = `BWB_TGT_CARD;
      dec_bad   = !is64;
      case (qidx)
        2'h0:    dec_cards = 8'h55;
        2'h1:    dec_cards = 8'haa;
        2'h2:    dec_cards = 8'h0f;
        default: dec_cards = 8'hf0;
      endcase
      dec_swap = halfword_swap_control_reg[4'hb + {2'h0, qidx}];
    end else if (offs >= `BWB_WIN_BCAST && offs <= `BWB_WIN_BCAST_END) begin
      dec_class = `BWB_TGT_CARD;
      dec_cards = 8'hff;
      dec_bad   = !i_cyc_write;
    end else if (offs[27:26] != 2'h0) begin
      dec_class = `BWB_TGT_IMAGE;
      dec_image = offs[27:26];
      dec_swap  = (offs[27:26] == 2'h2) ? halfword_swap_control_reg[0] :
                  (offs[27:26] == 2'h3) ? halfword_swap_control_reg[1] : 1'b0;
    end else begin
      dec_bad = 1'b1;
    end
  end

  reg [1:0] pf_code;
  reg [1:0] th_code;
  always @* begin
    if (dec_class == `BWB_TGT_IMAGE) begin
      pf_code = image_prefetch_depth_reg[2*(dec_image-2'h1) +: 2];
      th_code = image_write_threshold_reg[2*(dec_image-2'h1) +: 2];
    end else begin
      pf_code = min_code(card_prefetch_depth_reg, dec_cards);
      th_code = min_code(card_write_threshold_reg, dec_cards);
    end
  end

  // ****************************************
  // Cycle sequencer
  // ****************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;

  reg  [1:0]  state_reg;
  reg         swap_reg;
  reg         wide_reg;
  wire        wbuf_ready;
  // Swapping only applies to 32-bit and 64-bit cycles
  wire        swap_now = dec_swap && !is16;
  wire [63:0] wr_data  = swap_now ? swap_halves(i_cyc_wdata, is64) : i_cyc_wdata;
  wire        accept  = i_cyc_valid && (state_reg == ST_IDLE) && hit;

  // A write into a full buffer stalls the master
  assign o_cyc_ready = (state_reg == ST_IDLE) && (!i_cyc_write || wbuf_ready);

  bwb_fifo #(
    .WIDTH (64),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_wbuf (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_data    (wr_data),
    .i_valid   (accept && i_cyc_write && !dec_bad && dec_class != `BWB_TGT_NONE),
    .o_ready   (wbuf_ready),
    .o_data    (o_wbuf_data),
    .o_valid   (o_wbuf_valid),
    .i_ready   (i_wbuf_ready),
    .o_level   ()
  );

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg             <= ST_IDLE;
      swap_reg              <= 1'b0;
      wide_reg              <= 1'b0;
      o_cyc_done            <= 1'b0;
      o_cyc_err             <= 1'b0;
      o_cyc_rdata           <= 64'h0;
      o_tgt_class           <= `BWB_TGT_NONE;
      o_tgt_cards           <= 8'h00;
      o_tgt_image           <= 2'h0;
      o_tgt_offset          <= 23'h0;
      o_tgt_write           <= 1'b0;
      o_tgt_prefetch_beats  <= `BWB_BEATS_00;
      o_tgt_threshold_beats <= `BWB_BEATS_00;
      o_tgt_beat_bytes      <= 4'h2;
      o_tgt_req             <= 1'b0;
    end else begin
      o_cyc_done <= 1'b0;
      o_cyc_err  <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (accept && o_cyc_ready) begin
            if (dec_bad || dec_class == `BWB_TGT_NONE) begin
              o_cyc_done <= 1'b1;
              o_cyc_err  <= 1'b1;
            end else begin
              o_tgt_class           <= dec_class;
              o_tgt_cards           <= dec_cards;
              o_tgt_image           <= dec_image;
              o_tgt_offset          <= offs[22:0];
              o_tgt_write           <= i_cyc_write;
              o_tgt_prefetch_beats  <= i_cyc_write ? `BWB_BEATS_00 : beats_of(pf_code);
              o_tgt_threshold_beats <= beats_of(th_code);
              o_tgt_beat_bytes      <= is64 ? 4'h8 : (is16 ? 4'h2 : 4'h4);
              o_tgt_req             <= 1'b1;
              swap_reg              <= swap_now;
              wide_reg              <= is64;
              state_reg             <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (i_tgt_ack) begin
            o_tgt_req   <= 1'b0;
            o_cyc_done  <= 1'b1;
            o_cyc_rdata <= swap_reg ? swap_halves(i_tgt_rdata, wide_reg) : i_tgt_rdata;
            state_reg   <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  wire unused_ok = &{1'b0, i_cfg_rd};
endmodule

`default_nettype wire

// file: testbench/bwb_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Decode and handshake checker
// ****************************************
module bwb_chk (
  input wire logic        i_mclk,
  input wire logic        i_sys_rst,
  input wire logic        i_cyc_valid,
  input wire logic        o_cyc_ready,
  input wire logic [31:0] i_cyc_addr,
  input wire logic [1:0]  i_cyc_kind,
  input wire logic        i_cyc_width,
  input wire logic        i_cyc_write,
  input wire logic        o_cyc_done,
  input wire logic        o_cyc_err,
  input wire logic        o_tgt_req,
  input wire logic        i_tgt_ack,
  input wire logic [3:0]  o_tgt_beat_bytes,
  input wire logic        o_window_enable
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  wire        take;
  wire [27:0] ofs;
  assign take = i_cyc_valid && o_cyc_ready;
  assign ofs  = i_cyc_addr[27:0];
  // ****************************************
  // Assertions
  // ****************************************
  err_done_a: assert property (o_cyc_err |-> o_cyc_done)
    else $error("bus error without done");
  req_hold_a: assert property (o_tgt_req && !i_tgt_ack |=> o_tgt_req)
    else $error("target request dropped before ack");
  ack_done_a: assert property (o_tgt_req && i_tgt_ack |=> o_cyc_done && !o_cyc_err)
    else $error("no clean done after ack");
  busy_ready_a: assert property (o_tgt_req |-> !o_cyc_ready)
    else $error("ready while target busy");
  beat_size_a: assert property ($rose(o_tgt_req) |-> o_tgt_beat_bytes ==
    ($past(i_cyc_kind[1]) ? 4'h8 : ($past(i_cyc_width) ? 4'h4 : 4'h2)))
    else $error("beat size not cycle width");
  pair_narrow_a: assert property (take && ofs >= 28'h2200000 && ofs < 28'h2400000
    && !i_cyc_kind[1] && !i_cyc_width |=> !o_tgt_req)
    else $error("16-bit cycle forwarded to paired window");
  quad_narrow_a: assert property (take && ofs >= 28'h2400000 && ofs < 28'h2600000
    && !i_cyc_kind[1] |=> !o_tgt_req)
    else $error("narrow cycle forwarded to quad window");
  bcast_read_a: assert property (take && ofs >= 28'h2600000 && ofs < 28'h2620000
    && !i_cyc_write |=> !o_tgt_req)
    else $error("read forwarded to broadcast window");
  window_off_a: assert property (take && !o_window_enable |=> !o_cyc_done && !o_tgt_req)
    else $error("cycle answered while window disabled");
  hole_a: assert property (take && ofs >= 28'h2100000 && ofs < 28'h2200000 |=> !o_tgt_req)
    else $error("reserved range forwarded");
  cover property (o_cyc_err);
  cover property (o_tgt_req && i_tgt_ack);
  cover property (take && i_cyc_write);
endmodule

bind bwb_bridge bwb_chk chk_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
  .i_cyc_valid(i_cyc_valid), .o_cyc_ready(o_cyc_ready), .i_cyc_addr(i_cyc_addr),
  .i_cyc_kind(i_cyc_kind), .i_cyc_width(i_cyc_width), .i_cyc_write(i_cyc_write),
  .o_cyc_done(o_cyc_done), .o_cyc_err(o_cyc_err), .o_tgt_req(o_tgt_req),
  .i_tgt_ack(i_tgt_ack), .o_tgt_beat_bytes(o_tgt_beat_bytes),
  .o_window_enable(o_window_enable));
`default_nettype wire

// file: testbench/bwb_master_bfm.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Backplane master and card-side responder
// ****************************************
module bwb_master_bfm (
  input  wire logic        i_mclk,
  input  wire logic        i_ready,
  input  wire logic        i_req,
  output logic             o_valid,
  output logic [31:0]      o_addr,
  output logic [1:0]       o_kind,
  output logic             o_width,
  output logic             o_write,
  output logic [63:0]      o_wdata,
  output logic             o_ack,
  output logic [63:0]      o_rdata
);
  localparam logic [63:0] RD_PAT = 64'h1122334455667788;
  int ack_wait = 0;
  int wait_cnt = 0;
  bit timed_out = 0;
  initial begin
    {o_valid, o_addr, o_kind, o_width, o_write, o_wdata} = '0;
    {o_ack, o_rdata} = {1'b0, ~RD_PAT};
  end
  // Released data shows the inverse so a stale value never passes
  always @(posedge i_mclk) begin
    #1;
    {o_ack, o_rdata} = {1'b0, ~RD_PAT};
    if (i_req && wait_cnt >= ack_wait) begin
      {o_ack, o_rdata} = {1'b1, RD_PAT};
      wait_cnt = 0;
    end else if (i_req) begin
      wait_cnt++;
    end
  end
  // Addresses handed in are always aligned to the cycle width
  task automatic issue(input logic [31:0] a, input logic [1:0] k, input logic w,
                       input logic wr, input logic [63:0] d, input int lim);
    int n;
    @(posedge i_mclk);
    #1;
    {o_valid, o_addr, o_kind, o_width, o_write, o_wdata} = {1'b1, a, k, w, wr, d};
    // Ready is read at the edge itself, the value the block samples there
    timed_out = 1'b1;
    for (n = 0; n < lim && timed_out; n++) begin
      @(posedge i_mclk);
      timed_out = !i_ready;
    end
    #1;
    {o_valid, o_addr, o_wdata} = {1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bwb_regs.vh"
module tb;
  logic        i_mclk = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_wr = 1'b0;
  logic [5:0]  cfg_addr = 6'h00;
  logic [15:0] cfg_wdata = 16'h0000;
  logic        wb_rdy = 1'b1;
  wire  [15:0] cfg_rdata;
  wire         rdy, valid, width, write, done, err, req, ack, twr, wb_vld, win_en;
  wire  [31:0] addr;
  wire  [1:0]  kind, img;
  wire  [63:0] wdata, rdata, trd, wb_d;
  wire  [2:0]  cls;
  wire  [7:0]  cards;
  wire  [6:0]  pfb, thb;
  wire  [3:0]  bb;
  wire  [22:0] tofs;
  logic        g_done, g_err;
  logic [63:0] g_rd;
  logic [6:0]  g_pf, g_th;
  logic [7:0]  g_cards;
  logic [2:0]  g_cls;
  logic [1:0]  g_img;
  int          miscompares = 0;
  int          total_checks = 0;
  always #2.5 i_mclk = ~i_mclk;
  bwb_bridge #(.OPTION_CODE(8'h3c)) dut_u (.i_mclk(i_mclk), .i_sys_rst(rst),
    .i_cfg_wr(cfg_wr), .i_cfg_rd(1'b0), .i_cfg_addr(cfg_addr), .i_cfg_wdata(cfg_wdata),
    .o_cfg_rdata(cfg_rdata), .i_cyc_valid(valid), .o_cyc_ready(rdy), .i_cyc_addr(addr),
    .i_cyc_kind(kind), .i_cyc_width(width), .i_cyc_write(write), .i_cyc_wdata(wdata),
    .o_cyc_done(done), .o_cyc_err(err), .o_cyc_rdata(rdata), .o_tgt_class(cls),
    .o_tgt_cards(cards), .o_tgt_image(img), .o_tgt_offset(tofs), .o_tgt_write(twr),
    .o_tgt_prefetch_beats(pfb), .o_tgt_threshold_beats(thb), .o_tgt_beat_bytes(bb),
    .o_tgt_req(req), .i_tgt_ack(ack), .i_tgt_rdata(trd), .o_wbuf_data(wb_d),
    .o_wbuf_valid(wb_vld), .i_wbuf_ready(wb_rdy), .o_window_enable(win_en));
  bwb_master_bfm pm_u (.i_mclk(i_mclk), .i_ready(rdy), .i_req(req), .o_valid(valid),
    .o_addr(addr), .o_kind(kind), .o_width(width), .o_write(write), .o_wdata(wdata),
    .o_ack(ack), .o_rdata(trd));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cfg(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    #1;
    {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
    @(posedge i_mclk);
    #1;
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    cfg_addr = a;
    #1;
    chk("config read", {48'h0, exp}, {48'h0, cfg_rdata});
  endtask
  // Ignored cycles give no done, so the done wait is a fixed window
  task automatic cyc(input logic [27:0] o, input logic [1:0] k, input logic w,
                     input logic wr, input logic [63:0] d);
    int n;
    {g_done, g_err} = 2'b00;
    pm_u.issue({4'h3, o}, k, w, wr, d, 40);
    if (pm_u.timed_out) begin
      chk("cycle taken", 1, 0);
      stop_test();
    end
    for (n = 0; n < 20 && !g_done; n++) begin
      if (req)
        {g_cls, g_cards, g_img, g_pf, g_th} = {cls, cards, img, pfb, thb};
      if (done)
        {g_done, g_err, g_rd} = {2'b11 & {1'b1, err}, rdata};
      if (!g_done) begin
        @(posedge i_mclk);
        #1;
      end
    end
  endtask
  function automatic logic [6:0] beats(input logic [1:0] c);
    return (c == 2'h0) ? 7'h01 : (c == 2'h1) ? 7'h08 : (c == 2'h2) ? 7'h10 : 7'h40;
  endfunction
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [5:0]  ra [6] = '{`BWB_OFS_CARD_PFS, `BWB_OFS_IMAGE_PFS, `BWB_OFS_CARD_WTH,
                            `BWB_OFS_IMAGE_WTH, `BWB_OFS_SWAP, 6'h1c};
    logic [15:0] rm [6] = '{16'hffff, 16'h003f, 16'hffff, 16'h003f, 16'h7fff, 16'h0000};
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], 16'h0000);
      cfg(ra[i], 16'hffff);
      rd(ra[i], rm[i]);
    end
    cfg(`BWB_OFS_OPTION, 16'hffff);
    rd(`BWB_OFS_OPTION, 16'h003c);
  endtask
  task automatic t_window;
    int n = 0;
    cyc(28'h2000000, `BWB_CYC_SCT, `BWB_W32, 1'b0, 64'h0);
    chk("disabled done", 0, g_done);
    cfg(`BWB_OFS_OFFSET, 16'h3000);
    cfg(`BWB_OFS_CONTROL, 16'h8000);
    chk("window enable", 1, win_en);
    pm_u.issue(32'h4200_0000, `BWB_CYC_SCT, `BWB_W32, 1'b0, 64'h0, 40);
    repeat (20) begin
      @(posedge i_mclk);
      #1;
      n += done;
    end
    chk("foreign base done", 0, n);
  endtask
  task automatic t_depth;
    logic [15:0] pf = 16'h1be4;
    logic [15:0] th = 16'he41b;
    cfg(`BWB_OFS_CARD_PFS, pf);
    cfg(`BWB_OFS_CARD_WTH, th);
    for (int k = 0; k < 8; k++) begin
      cyc(28'h2000000 + 28'h20000 * k, k[1:0], k[2], 1'b0, 64'h0);
      chk("card mask", 8'h01 << k, g_cards);
      chk("prefetch", beats(pf[2*k +: 2]), g_pf);
      chk("beat bytes", (k[1] ? 4'h8 : (k[2] ? 4'h4 : 4'h2)), bb);
      cyc(28'h2000000 + 28'h20000 * k, k[1:0], k[2], 1'b1, 64'h0);
      chk("threshold", beats(th[2*k +: 2]), g_th);
    end
  endtask
  task automatic t_min;
    pm_u.ack_wait = 3;
    cyc(28'h2280000, `BWB_CYC_BLT, `BWB_W32, 1'b0, 64'h0);
    chk("pair prefetch", 7'h08, g_pf);
    chk("pair mask", 8'h50, g_cards);
    chk("read offset", {1'b0, 23'h280000}, {twr, tofs});
    cyc(28'h22c0000, `BWB_CYC_SCT, `BWB_W32, 1'b1, 64'h0);
    chk("pair threshold", 7'h08, g_th);
    chk("write offset", {1'b1, 23'h2c0000}, {twr, tofs});
    cyc(28'h2600000, `BWB_CYC_MBLT, `BWB_W32, 1'b1, 64'h0);
    chk("broadcast mask", 8'hff, g_cards);
    cfg(`BWB_OFS_CARD_PFS, 16'h5be4);
    cyc(28'h23c0000, `BWB_CYC_BLT, `BWB_W32, 1'b0, 64'h0);
    chk("double card prefetch", 7'h08, g_pf);
    pm_u.ack_wait = 0;
  endtask
  task automatic t_swap;
    int n = 0;
    cfg(`BWB_OFS_SWAP, 16'h0a02);
    cyc(28'h2200000, `BWB_CYC_SCT, `BWB_W32, 1'b0, 64'h0);
    chk("pair swap", 32'h77885566, g_rd[31:0]);
    cyc(28'h2300000, `BWB_CYC_SCT, `BWB_W32, 1'b0, 64'h0);
    chk("pair no swap", 32'h55667788, g_rd[31:0]);
    cyc(28'hc000000, `BWB_CYC_2E, `BWB_W32, 1'b0, 64'h0);
    chk("image swap", 64'h3344112277885566, g_rd);
    chk("image sel", {3'h3, 2'h3}, {g_cls, g_img});
    chk("image prefetch", 7'h40, g_pf);
    wb_rdy = 1'b0;
    for (int i = 0; i < 8; i++)
      cyc(28'h2400000, `BWB_CYC_MBLT, `BWB_W32, 1'b1, 64'haaaabbbbccccdddd);
    chk("write swap", 64'hbbbbaaaaddddcccc, wb_d);
    pm_u.issue(32'h3240_0000, `BWB_CYC_MBLT, `BWB_W32, 1'b1, 64'h0, 5);
    chk("full refusal", 1, pm_u.timed_out);
    wb_rdy = 1'b1;
    repeat (12) begin
      if (wb_vld === 1'b1)
        n++;
      @(posedge i_mclk);
      #1;
    end
    chk("drained words", 8, n);
  endtask
  task automatic t_errs;
    logic [27:0] ea [6] = '{28'h2200000, 28'h2500000, 28'h2600000, 28'h2100000,
                            28'h2620000, 28'h0000100};
    logic [1:0]  ek [6] = '{`BWB_CYC_SCT, `BWB_CYC_BLT, `BWB_CYC_MBLT, `BWB_CYC_SCT,
                            `BWB_CYC_BLT, `BWB_CYC_SCT};
    logic        ew [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    for (int i = 0; i < 6; i++) begin
      cyc(ea[i], ek[i], ew[i], 1'b0, 64'h0);
      chk("bus error", {i != 5, 1'b1}, {g_err, g_done});
    end
    chk("common class", 3'h1, g_cls);
    cyc(28'h8000000, `BWB_CYC_SCT, `BWB_W16, 1'b0, 64'h0);
    chk("image two", {3'h3, 2'h2}, {g_cls, g_img});
  endtask
  initial begin
    repeat (16) @(posedge i_mclk);
    #1;
    rst = 1'b0;
    t_regs();
    t_window();
    t_depth();
    t_min();
    t_swap();
    t_errs();
    stop_test();
  end
endmodule
`default_nettype wire
